/* File: core/stwcs_bitrate.v */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bit-rate divider
// ----------------------------------------------------------------
module stwcs_bitrate (
    input wire core_clk_i,
    input wire reset_i,
    input wire run_i,
    input wire [7:0] divisor_i,
    output reg tick_o,
    output reg half_o
);

    reg [7:0] count_r;

    always @(posedge core_clk_i) begin
        if (reset_i || !run_i) begin
            count_r <= divisor_i;
            tick_o <= 1'b0;
            half_o <= 1'b0;
        end else begin
            // one period per terminal count, then reload
            tick_o <= (count_r == 8'h00);
            half_o <= (count_r == {1'b0, divisor_i[7:1]});
            if (count_r == 8'h00) begin
                count_r <= divisor_i;
            end else begin
                count_r <= count_r - 8'h01;
            end
        end
    end

endmodule

/* File: core/stwcs_core.v */
`timescale 1ns/1ps
`include "stwcs_defs.vh"
// How it works
// - control register readable, writable; hardware alters two bits
// - enable bit switches the engine on, off
// - start request enters master, starts when free
// - master stop request sends stop, self-clears
// - slave stop request returns to not addressed
// - stop request forced zero while disabled
// - new state sets flag; interrupt needs both enables
// - ack bit one drives data low on ack
// - ack bit zero leaves data high on ack
// - state register: code in upper five bits
// - state field holds one of 19 codes
// - idle code means nothing pending; others flag
// - state valid one cycle after flag edges
// - master bit rate is clock over divisor plus one
// - slave ignores divisor, follows master clock
module stwcs_core (
    input wire core_clk_i,
    input wire reset_i,
    input wire ctrl_wr_i,
    input wire [7:0] ctrl_wdata_i,
    input wire divisor_wr_i,
    input wire [7:0] divisor_wdata_i,
    input wire [7:0] tx_byte_i,
    input wire [6:0] own_addr_i,
    input wire global_irq_enable_i,
    input wire serial_irq_enable_i,
    input wire sda_i,
    input wire scl_i,
    output reg [7:0] serial_two_wire_control_o,
    output reg [7:0] serial_two_wire_state_o,
    output reg [7:0] bit_rate_divisor_o,
    output reg [7:0] rx_byte_o,
    output reg irq_o,
    output reg sda_o,
    output reg sda_oe_o,
    output reg scl_o,
    output reg scl_oe_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg enable_r;
    reg start_req_r;
    reg stop_req_r;
    reg si_r;
    reg ack_en_r;
    reg si_q_r;
    reg [7:0] code_r;
    reg [7:0] state_code_r;
    reg [7:0] divisor_r;
    reg [2:0] st_r;
    reg master_r;
    reg xmit_r;
    reg addr_ph_r;
    reg ack_r;
    reg ack_seen_r;
    reg last_r;
    reg busy_r;
    reg [3:0] bitcnt_r;
    reg [7:0] shreg_r;
    reg sda_q_r;
    reg scl_q_r;
    wire tick;
    wire half;
    wire start_det;
    wire stop_det;
    wire scl_rise;
    wire scl_fall;
    wire rw_bit;

    assign start_det = scl_i & scl_q_r & sda_q_r & ~sda_i;
    assign stop_det = scl_i & scl_q_r & ~sda_q_r & sda_i;
    assign scl_rise = scl_i & ~scl_q_r;
    assign scl_fall = ~scl_i & scl_q_r;
    assign rw_bit = shreg_r[0];

    // ------------------------------------------------------------
    // bit-rate divider, master only
    // ------------------------------------------------------------
    // divider idles in slave mode so the divisor has no effect
    stwcs_bitrate u_bitrate (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .run_i(master_r),
        .divisor_i(divisor_r),
        .tick_o(tick),
        .half_o(half)
    );

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            serial_two_wire_control_o <= `STWCS_CTRL_RST;
            serial_two_wire_state_o <= `STWCS_C_IDLE;
            bit_rate_divisor_o <= `STWCS_DIV_RST;
            rx_byte_o <= `STWCS_BYTE_RST;
            irq_o <= 1'b0;
            // open drain: the pins only ever pull low
            sda_o <= 1'b0;
            scl_o <= 1'b0;
        end else begin
            serial_two_wire_control_o <= `STWCS_CTRL_RST;
            serial_two_wire_control_o[`STWCS_EN_BIT] <= enable_r;
            serial_two_wire_control_o[`STWCS_START_BIT] <= start_req_r;
            serial_two_wire_control_o[`STWCS_STOP_BIT] <= stop_req_r;
            serial_two_wire_control_o[`STWCS_SI_BIT] <= si_r;
            serial_two_wire_control_o[`STWCS_ACKEN_BIT] <= ack_en_r;
            serial_two_wire_state_o <=
                {state_code_r[7:3], `STWCS_STAT_ZERO};
            bit_rate_divisor_o <= divisor_r;
            rx_byte_o <= shreg_r;
            irq_o <= si_r & global_irq_enable_i &
                serial_irq_enable_i;
        end
    end

    // ------------------------------------------------------------
    // control, state code and engine
    // ------------------------------------------------------------
    // later assignments in this block override earlier ones, so a
    // hardware flag set in the same cycle as a clear write wins
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            enable_r <= 1'b0;
            start_req_r <= 1'b0;
            stop_req_r <= 1'b0;
            si_r <= 1'b0;
            ack_en_r <= 1'b0;
            si_q_r <= 1'b0;
            code_r <= `STWCS_C_IDLE;
            state_code_r <= `STWCS_C_IDLE;
            divisor_r <= `STWCS_DIV_RST;
            st_r <= `STWCS_ST_IDLE;
            master_r <= 1'b0;
            xmit_r <= 1'b0;
            addr_ph_r <= 1'b0;
            ack_r <= 1'b0;
            ack_seen_r <= 1'b0;
            last_r <= 1'b0;
            busy_r <= 1'b0;
            bitcnt_r <= `STWCS_BIT_FIRST;
            shreg_r <= `STWCS_BYTE_RST;
            sda_q_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end else begin
            sda_q_r <= sda_i;
            scl_q_r <= scl_i;
            si_q_r <= si_r;
            if (divisor_wr_i) begin
                divisor_r <= divisor_wdata_i;
            end
            if (ctrl_wr_i) begin
                enable_r <= ctrl_wdata_i[`STWCS_EN_BIT];
                start_req_r <= ctrl_wdata_i[`STWCS_START_BIT];
                // a stop written together with enable low never lands
                stop_req_r <= ctrl_wdata_i[`STWCS_STOP_BIT] &
                    ctrl_wdata_i[`STWCS_EN_BIT];
                ack_en_r <= ctrl_wdata_i[`STWCS_ACKEN_BIT];
                if (!ctrl_wdata_i[`STWCS_SI_BIT]) begin
                    si_r <= 1'b0;
                end
            end
            // code lands one cycle after the flag rises, idle code
            // one cycle after it falls
            if (si_r && !si_q_r) begin
                state_code_r <= code_r;
            end else if (!si_r && si_q_r) begin
                state_code_r <= `STWCS_C_IDLE;
            end
            if (start_det) begin
                busy_r <= 1'b1;
            end else if (stop_det) begin
                busy_r <= 1'b0;
            end
            if (!enable_r) begin
                st_r <= `STWCS_ST_IDLE;
                master_r <= 1'b0;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
                stop_req_r <= 1'b0;
            end else if (!master_r && stop_det &&
                         st_r != `STWCS_ST_IDLE) begin
                st_r <= `STWCS_ST_IDLE;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
                si_r <= 1'b1;
                code_r <= `STWCS_C_SSTOP;
            end else if (!master_r && start_det) begin
                // own address is listened for on every start
                st_r <= `STWCS_ST_BIT;
                xmit_r <= 1'b0;
                addr_ph_r <= 1'b1;
                last_r <= 1'b0;
                bitcnt_r <= `STWCS_BIT_FIRST;
                ack_r <= ack_en_r;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
            end else begin
                case (st_r)
                `STWCS_ST_IDLE: begin
                    sda_oe_o <= 1'b0;
                    scl_oe_o <= 1'b0;
                    if (start_req_r && !busy_r && !si_r) begin
                        master_r <= 1'b1;
                        st_r <= `STWCS_ST_START;
                        sda_oe_o <= 1'b1;
                    end
                end
                `STWCS_ST_START: begin
                    if (tick) begin
                        scl_oe_o <= 1'b1;
                        addr_ph_r <= 1'b1;
                        last_r <= 1'b0;
                        st_r <= `STWCS_ST_HOLD;
                        si_r <= 1'b1;
                        code_r <= `STWCS_C_START;
                    end
                end
                `STWCS_ST_RSTA: begin
                    if (scl_oe_o && half) begin
                        scl_oe_o <= 1'b0;
                    end else if (!scl_oe_o && scl_i && tick) begin
                        if (sda_oe_o) begin
                            scl_oe_o <= 1'b1;
                            addr_ph_r <= 1'b1;
                            st_r <= `STWCS_ST_HOLD;
                            si_r <= 1'b1;
                            code_r <= `STWCS_C_RSTART;
                        end else begin
                            sda_oe_o <= 1'b1;
                        end
                    end
                end
                `STWCS_ST_STOP: begin
                    if (scl_oe_o && half) begin
                        scl_oe_o <= 1'b0;
                    end else if (!scl_oe_o && scl_i && tick) begin
                        sda_oe_o <= 1'b0;
                    end
                    if (stop_det) begin
                        stop_req_r <= 1'b0;
                        master_r <= 1'b0;
                        st_r <= `STWCS_ST_IDLE;
                    end
                end
                `STWCS_ST_HOLD: begin
                    // clock held low while software services the flag
                    scl_oe_o <= 1'b1;
                    if (!si_r) begin
                        if (stop_req_r && master_r) begin
                            st_r <= `STWCS_ST_STOP;
                            sda_oe_o <= 1'b1;
                        end else if (stop_req_r || last_r) begin
                            stop_req_r <= 1'b0;
                            st_r <= `STWCS_ST_IDLE;
                            sda_oe_o <= 1'b0;
                            scl_oe_o <= 1'b0;
                        end else if (master_r && start_req_r) begin
                            st_r <= `STWCS_ST_RSTA;
                            sda_oe_o <= 1'b0;
                        end else begin
                            st_r <= `STWCS_ST_BIT;
                            bitcnt_r <= `STWCS_BIT_FIRST;
                            ack_r <= ack_en_r;
                            scl_oe_o <= master_r;
                            if ((master_r && addr_ph_r) || xmit_r) begin
                                xmit_r <= 1'b1;
                                shreg_r <= tx_byte_i;
                                sda_oe_o <= ~tx_byte_i[7];
                            end else begin
                                sda_oe_o <= 1'b0;
                            end
                        end
                    end
                end
                `STWCS_ST_BIT: begin
                    if (master_r) begin
                        if (scl_oe_o && half) begin
                            scl_oe_o <= 1'b0;
                        end else if (!scl_oe_o && scl_i && tick) begin
                            scl_oe_o <= 1'b1;
                        end
                    end
                    if (scl_rise) begin
                        if (bitcnt_r != `STWCS_BIT_ACK) begin
                            shreg_r <= {shreg_r[6:0], sda_i};
                            if (master_r && xmit_r && !sda_oe_o &&
                                !sda_i) begin
                                master_r <= 1'b0;
                                st_r <= `STWCS_ST_IDLE;
                                sda_oe_o <= 1'b0;
                                scl_oe_o <= 1'b0;
                                si_r <= 1'b1;
                                code_r <= `STWCS_C_ARB_LOST;
                            end
                        end else begin
                            ack_seen_r <= ~sda_i;
                        end
                    end else if (scl_fall) begin
                        if (bitcnt_r < `STWCS_BIT_LAST_DATA) begin
                            bitcnt_r <= bitcnt_r + 4'h1;
                            sda_oe_o <= xmit_r & ~shreg_r[7];
                        end else if (bitcnt_r == `STWCS_BIT_LAST_DATA) begin
                            bitcnt_r <= `STWCS_BIT_ACK;
                            if (!master_r && addr_ph_r) begin
                                if (shreg_r[7:1] == own_addr_i && ack_r) begin
                                    sda_oe_o <= 1'b1;
                                end else begin
                                    st_r <= `STWCS_ST_IDLE;
                                    sda_oe_o <= 1'b0;
                                end
                            end else begin
                                sda_oe_o <= ~xmit_r & ack_r;
                            end
                        end else begin
                            sda_oe_o <= 1'b0;
                            scl_oe_o <= 1'b1;
                            st_r <= `STWCS_ST_HOLD;
                            addr_ph_r <= 1'b0;
                            si_r <= 1'b1;
                            if (master_r && addr_ph_r) begin
                                xmit_r <= ~rw_bit;
                                if (rw_bit) begin
                                    code_r <= ack_seen_r ?
                                        `STWCS_C_MR_ACK : `STWCS_C_MR_NACK;
                                end else begin
                                    code_r <= ack_seen_r ?
                                        `STWCS_C_MW_ACK : `STWCS_C_MW_NACK;
                                end
                            end else if (master_r) begin
                                if (xmit_r) begin
                                    code_r <= ack_seen_r ?
                                        `STWCS_C_MTD_ACK : `STWCS_C_MTD_NACK;
                                end else begin
                                    code_r <= ack_r ?
                                        `STWCS_C_MRD_ACK : `STWCS_C_MRD_NACK;
                                end
                            end else if (addr_ph_r) begin
                                xmit_r <= rw_bit;
                                code_r <= rw_bit ?
                                    `STWCS_C_SR_ACK : `STWCS_C_SW_ACK;
                            end else if (xmit_r) begin
                                last_r <= ~ack_seen_r;
                                code_r <= ack_seen_r ?
                                    `STWCS_C_STD_ACK : `STWCS_C_STD_NACK;
                            end else begin
                                last_r <= ~ack_r;
                                code_r <= ack_r ?
                                    `STWCS_C_SRD_ACK : `STWCS_C_SRD_NACK;
                            end
                        end
                    end
                end
                default: begin
                    st_r <= `STWCS_ST_IDLE;
                end
                endcase
            end
        end
    end

endmodule

/* File: shared/stwcs_defs.vh */
`ifndef STWCS_DEFS_VH
`define STWCS_DEFS_VH

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define STWCS_EN_BIT 6
`define STWCS_START_BIT 5
`define STWCS_STOP_BIT 4
`define STWCS_SI_BIT 3
`define STWCS_ACKEN_BIT 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define STWCS_CTRL_RST 8'h00
`define STWCS_DIV_RST 8'h00
`define STWCS_BYTE_RST 8'h00

// ----------------------------------------------------------------
// protocol state codes
// ----------------------------------------------------------------
`define STWCS_C_IDLE 8'hF8
`define STWCS_C_START 8'h08
`define STWCS_C_RSTART 8'h10
`define STWCS_C_MW_ACK 8'h18
`define STWCS_C_MW_NACK 8'h20
`define STWCS_C_MTD_ACK 8'h28
`define STWCS_C_MTD_NACK 8'h30
`define STWCS_C_ARB_LOST 8'h38
`define STWCS_C_MR_ACK 8'h40
`define STWCS_C_MR_NACK 8'h48
`define STWCS_C_MRD_ACK 8'h50
`define STWCS_C_MRD_NACK 8'h58
`define STWCS_C_SW_ACK 8'h60
`define STWCS_C_SRD_ACK 8'h80
`define STWCS_C_SRD_NACK 8'h88
`define STWCS_C_SSTOP 8'hA0
`define STWCS_C_SR_ACK 8'hA8
`define STWCS_C_STD_ACK 8'hB8
`define STWCS_C_STD_NACK 8'hC0

// ----------------------------------------------------------------
// engine states and bit counter
// ----------------------------------------------------------------
`define STWCS_ST_IDLE 3'h0
`define STWCS_ST_START 3'h1
`define STWCS_ST_BIT 3'h2
`define STWCS_ST_HOLD 3'h3
`define STWCS_ST_STOP 3'h4
`define STWCS_ST_RSTA 3'h5
`define STWCS_BIT_FIRST 4'h0
`define STWCS_BIT_LAST_DATA 4'h7
`define STWCS_BIT_ACK 4'h8
`define STWCS_STAT_ZERO 3'h0

`endif

/* File: test/stwcs_core_sva.sv */
`timescale 1ns/1ps
`include "stwcs_defs.vh"
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module stwcs_core_sva (
    input wire core_clk_i,
    input wire reset_i,
    input wire ctrl_wr_i,
    input wire [7:0] ctrl_wdata_i,
    input wire global_irq_enable_i,
    input wire serial_irq_enable_i,
    input wire sda_i,
    input wire scl_i,
    input wire [7:0] serial_two_wire_control_o,
    input wire [7:0] serial_two_wire_state_o,
    input wire irq_o,
    input wire sda_oe_o,
    input wire scl_oe_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    wire si = serial_two_wire_control_o[3];
    wire [7:0] st = serial_two_wire_state_o;
    sequence s_flag_up;
        !si ##1 si;
    endsequence
    sequence s_flag_held;
        si ##1 si;
    endsequence
    sequence s_flag_down;
        si ##1 si ##1 !si;
    endsequence
    a_state_low_zero: assert property (st[2:0] == 3'h0)
        else $error("state low bits not zero");
    a_code_on_flag: assert property (s_flag_up |=> st != `STWCS_C_IDLE)
        else $error("no code after flag rose");
    a_code_holds: assert property (s_flag_held |=> $stable(st))
        else $error("code moved while flag set");
    a_code_after_clear: assert property (s_flag_down |->
        $stable(st) ##1 st == `STWCS_C_IDLE)
        else $error("code not held then idle after clear");
    // flag drop must trace back to a clearing write two edges earlier
    a_flag_sw_clear: assert property (si ##1 !si |->
        $past(ctrl_wr_i, 2) && !$past(ctrl_wdata_i[3], 2))
        else $error("flag dropped without clearing write");
    a_irq_both_enables: assert property (irq_o == (si &&
        $past(global_irq_enable_i) && $past(serial_irq_enable_i)))
        else $error("irq not flag and both enables");
    a_stop_off_disabled: assert property (!serial_two_wire_control_o[6]
        |-> !serial_two_wire_control_o[4])
        else $error("stop request set while disabled");
    a_pins_off_disabled: assert property (!serial_two_wire_control_o[6]
        [*3] |-> !sda_oe_o && !scl_oe_o)
        else $error("pins pulled while disabled");
    a_stop_self_clear: assert property (serial_two_wire_control_o[4] &&
        scl_i && $rose(sda_i) |-> ##[1:6]
        !serial_two_wire_control_o[4])
        else $error("stop request not cleared after stop");
endmodule

/* File: test/stwcs_core_tb_top.sv */
`timescale 1ns/1ps
`include "stwcs_defs.vh"
module stwcs_core_tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg cwr = 1'b0;
    reg [7:0] cwd = 8'h00;
    reg dwr = 1'b0;
    reg [7:0] dwd = 8'h00;
    reg [7:0] txb = 8'h00;
    reg gie = 1'b0;
    reg sie = 1'b0;
    reg [7:0] rdb = 8'h00;
    reg [7:0] d;
    reg [7:0] dat;
    wire [7:0] ctl, st, div, rx, m_got;
    wire irq, sda_oe, scl_oe, m_pull, m_ack;
    // open-drain wires with pull-up, idle high
    wire sda = !(sda_oe | m_pull);
    wire scl = !scl_oe;
    integer seed = 72087;
    integer miscompares = 0;
    integer n_compared = 0;
    integer cyc = 0;
    integer last_r = 0;
    integer per = 0;
    integer i;
    always #5 clk = ~clk;
    always @(negedge clk) cyc = cyc + 1;
    always @(posedge scl_oe) begin
        per = cyc - last_r;
        last_r = cyc;
    end
    stwcs_core dut_u (.core_clk_i(clk), .reset_i(rst), .ctrl_wr_i(cwr),
        .ctrl_wdata_i(cwd), .divisor_wr_i(dwr), .divisor_wdata_i(dwd),
        .tx_byte_i(txb), .own_addr_i(7'h11), .global_irq_enable_i(gie),
        .serial_irq_enable_i(sie), .sda_i(sda), .scl_i(scl),
        .serial_two_wire_control_o(ctl), .serial_two_wire_state_o(st),
        .bit_rate_divisor_o(div), .rx_byte_o(rx), .irq_o(irq),
        .sda_o(), .sda_oe_o(sda_oe), .scl_o(), .scl_oe_o(scl_oe));
    stwcs_slave_model m_u (.scl_i(scl), .sda_i(sda), .rd_byte_i(rdb),
        .sda_pull_o(m_pull), .got_o(m_got), .got_ack_o(m_ack));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task cmp8(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("compared %0d miscompares %0d", n_compared,
                miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // readback lands one edge after the write edge
    task wr_ctrl(input [7:0] v);
        begin
            @(negedge clk);
            cwr = 1'b1;
            cwd = v;
            @(negedge clk);
            cwr = 1'b0;
            @(negedge clk);
        end
    endtask
    task xfer(input [7:0] v, input [7:0] code);
        begin
            wr_ctrl(v);
            repeat (3000) if (ctl[3] !== 1'b1) @(negedge clk);
            @(negedge clk);
            cmp8(st, code);
        end
    endtask
    task stop_bus;
        begin
            wr_ctrl(8'h54);
            repeat (3000) if (ctl[4] !== 1'b0) @(negedge clk);
            cmp8(ctl, 8'h44);
            repeat (2) @(negedge clk);
            cmp8(st, `STWCS_C_IDLE);
        end
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        cmp8(ctl, `STWCS_CTRL_RST);
        cmp8(st, `STWCS_C_IDLE);
        cmp8(div, `STWCS_DIV_RST);
        // enable low keeps the start request parked
        wr_ctrl(8'hBF);
        cmp8(ctl, 8'h24);
        for (i = 0; i < 8; i = i + 1) begin
            d = $random(seed);
            d[6] = 1'b0;
            wr_ctrl(d);
            cmp8(ctl, d & 8'h24);
        end
        wr_ctrl(8'h00);
        dat = $random(seed);
        d = 8'h02 + (dat & 8'h07);
        @(negedge clk);
        dwr = 1'b1;
        dwd = d;
        @(negedge clk);
        dwr = 1'b0;
        @(negedge clk);
        cmp8(div, d);
        txb = 8'h54;
        xfer(8'h64, `STWCS_C_START);
        for (i = 0; i < 4; i = i + 1) begin
            gie = i[0];
            sie = i[1];
            repeat (2) @(negedge clk);
            cmp8({7'h00, irq}, {7'h00, i[0] & i[1]});
        end
        xfer(8'h44, `STWCS_C_MW_ACK);
        cmp8(per[7:0], d + 8'h01);
        dat = $random(seed);
        txb = dat;
        xfer(8'h44, `STWCS_C_MTD_ACK);
        cmp8(m_got, dat);
        txb = 8'h55;
        xfer(8'h64, `STWCS_C_RSTART);
        xfer(8'h44, `STWCS_C_MR_ACK);
        rdb = $random(seed);
        xfer(8'h44, `STWCS_C_MRD_ACK);
        cmp8(rx, rdb);
        cmp8({7'h00, m_ack}, 8'h01);
        rdb = $random(seed);
        xfer(8'h40, `STWCS_C_MRD_NACK);
        cmp8(rx, rdb);
        cmp8({7'h00, m_ack}, 8'h00);
        stop_bus;
        // an address nobody answers
        txb = 8'h22;
        xfer(8'h64, `STWCS_C_START);
        xfer(8'h44, `STWCS_C_MW_NACK);
        stop_bus;
        wr_ctrl(8'h10);
        cmp8(ctl, 8'h00);
        test_done;
    end
    // whole run needs well under a millisecond at this divisor
    initial begin
        #300000;
        miscompares = miscompares + 1;
        test_done;
    end
endmodule
bind stwcs_core stwcs_core_sva chk_u (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
    .global_irq_enable_i(global_irq_enable_i),
    .serial_irq_enable_i(serial_irq_enable_i), .sda_i(sda_i),
    .scl_i(scl_i), .serial_two_wire_control_o(serial_two_wire_control_o),
    .serial_two_wire_state_o(serial_two_wire_state_o), .irq_o(irq_o),
    .sda_oe_o(sda_oe_o), .scl_oe_o(scl_oe_o));

/* File: test/stwcs_slave_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// behavioural bus slave
// ----------------------------------------------------------------
module stwcs_slave_model #(
    parameter [6:0] ADDR = 7'h2A
) (
    input wire scl_i,
    input wire sda_i,
    input wire [7:0] rd_byte_i,
    output reg sda_pull_o,
    output reg [7:0] got_o,
    output reg got_ack_o
);
    reg [7:0] sh = 8'h00;
    reg act = 1'b0;
    reg adr = 1'b0;
    reg rd = 1'b0;
    integer n = 0;
    initial begin
        sda_pull_o = 1'b0;
        got_o = 8'h00;
        got_ack_o = 1'b0;
    end
    always @(negedge sda_i) if (scl_i) begin
        n = 0;
        act = 1'b1;
        adr = 1'b1;
    end
    always @(posedge sda_i) if (scl_i) act = 1'b0;
    // next byte may be loaded while the master holds the clock low
    always @(rd_byte_i) if (act && rd && !adr && n == 0 && !scl_i)
        sda_pull_o = !rd_byte_i[7];
    always @(posedge scl_i) if (act) begin
        if (n < 8) sh = {sh[6:0], sda_i};
        else if (rd && !adr) got_ack_o = !sda_i;
        n = n + 1;
    end
    // changes only while clock is low, so never fakes start or stop
    always @(negedge scl_i) if (act) begin
        if (n == 8) begin
            if (adr) begin
                act = (sh[7:1] == ADDR);
                rd = sh[0];
            end else if (!rd) got_o = sh;
            sda_pull_o = act && !(rd && !adr);
        end else if (n == 9) begin
            n = 0;
            if (rd && !adr && !got_ack_o) act = 1'b0;
            adr = 1'b0;
            sda_pull_o = 1'b0;
        end
        if (act && rd && !adr && n < 8) sda_pull_o = !rd_byte_i[7 - n];
    end
endmodule
